// *** design/ufm_pkg.sv ***
// How it works
// - irq asserts only where status and mask both set
// - mask bit 7 gates input change events
// - mask bit 6 gates 64-bit-time receive watchdog
// - mask bit 5 gates address recognition changes
// - mask bit 4 gates flow character recognition
// - mask bit 3 gates counter/timer zero event
// - mask bit 2 gates receiver break change
// - mask bit 1 receive, bit 0 transmit service
// - receive fifo: 256 entries, 11 bits, status travels
// - data in 7:0, unused high bits zeroed
// - popped entry status updates status bits
// - block mode accumulates errors until command 0x04
// - transmit fifo 256 bytes; short characters drop high bits
// - receive level picks fill position for service
// - transmit level picks empty position for service
// - level write overrides mode register threshold
// - fill count, zero means 256 when ready
// - empty count, zero means 256 when ready
// - flow-on compare character resets to 0x11
// - flow-off compare character resets to 0x13
// - multidrop address character resets to 0x00
// - global config bit 0 masks status reads
// - watchdog restarts on any receive fifo event
//
// shared constants and carriers for the fifo/mask/char block.
// assumes one 25 MHz clock and a synchronous active-high reset.
package ufm_pkg;
  // ==========================================================
  // sizes
  localparam int CH_N = 2;
  localparam int FIFO_DEPTH = 256;
  localparam int PTR_W = 8;
  localparam int CNT_W = 9;
  localparam logic [8:0] FIFO_FULL = 9'h100;
  localparam logic [8:0] FIFO_EMPTY = 9'h000;
  // ==========================================================
  // register map: bit 4 picks channel, low nibble the register
  localparam int CH_SEL_BIT = 4;
  localparam logic [5:0] GLOBAL_ADDR = 6'h20;
  localparam logic [3:0] OFF_MASK = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h1;
  localparam logic [3:0] OFF_RXDATA = 4'h2;
  localparam logic [3:0] OFF_TXDATA = 4'h3;
  localparam logic [3:0] OFF_RXLEVEL = 4'h4;
  localparam logic [3:0] OFF_RXFILL = 4'h5;
  localparam logic [3:0] OFF_TXLEVEL = 4'h6;
  localparam logic [3:0] OFF_TXEMPTY = 4'h7;
  localparam logic [3:0] OFF_FLOW_ON = 4'h8;
  localparam logic [3:0] OFF_FLOW_OFF = 4'h9;
  localparam logic [3:0] OFF_ADDRCHAR = 4'ha;
  localparam logic [3:0] OFF_RXSTAT = 4'hb;
  // ==========================================================
  // reset values
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] RST_LEVEL = 8'h00;
  localparam logic [7:0] RST_FLOW_ON = 8'h11;
  localparam logic [7:0] RST_FLOW_OFF = 8'h13;
  localparam logic [7:0] RST_ADDRCHAR = 8'h00;
  localparam logic [7:0] RST_GLOBAL = 8'h00;
  // ==========================================================
  // interrupt status and global config bit positions
  localparam int IS_COS = 7;
  localparam int IS_WDOG = 6;
  localparam int IS_ADDR = 5;
  localparam int IS_FLOW = 4;
  localparam int IS_CT = 3;
  localparam int IS_BRK = 2;
  localparam int IS_RX = 1;
  localparam int IS_TX = 0;
  localparam int GC_MASKREAD = 0;
  // ==========================================================
  // commands and timing
  localparam logic [7:0] CMD_RESET_ERR = 8'h04;
  localparam logic [6:0] WDOG_BIT_TIMES = 7'd64;
  // character length codes: 0..3 mean 5..8 bits
  localparam logic [1:0] LEN_5 = 2'h0;
  localparam logic [1:0] LEN_6 = 2'h1;
  localparam logic [1:0] LEN_7 = 2'h2;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic brk;
    logic frm;
    logic par;
    logic [7:0] data;
  } ufm_rx_entry_t;
  typedef struct packed {
    logic input_change_detect;
    logic addr;
    logic flow;
    logic ct;
    logic brk;
  } ufm_ext_stat_t;
endpackage

// *** design/ufm_top.sv ***
// fifo storage, interrupt masking, level and count registers and
// character compare registers for both channels of a dual uart.
// assumes the receiver, transmitter and command logic share clk and
// hand over one-cycle strobes; register port answers reads next cycle.
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module ufm_top
  import ufm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [10:0] reg_rdata,
  // receiver side, per channel
  input wire logic [CH_N-1:0] rx_load,
  input wire ufm_rx_entry_t [CH_N-1:0] rx_entry,
  input wire logic [CH_N-1:0] bit_tick,
  input wire logic [CH_N-1:0][1:0] char_len,
  // mode and command inputs, per channel
  input wire logic [CH_N-1:0] block_err_mode,
  input wire logic [CH_N-1:0] cmd_valid,
  input wire logic [CH_N-1:0][7:0] cmd_code,
  input wire logic [CH_N-1:0][7:0] mode_rx_level,
  input wire logic [CH_N-1:0][7:0] mode_tx_level,
  input wire ufm_ext_stat_t [CH_N-1:0] ext_stat,
  // transmitter side, per channel
  input wire logic [CH_N-1:0] tx_take,
  output logic [CH_N-1:0][7:0] tx_data,
  output logic [CH_N-1:0] tx_valid,
  // status and recognition, per channel
  output logic [CH_N-1:0][2:0] rx_status,
  output logic [CH_N-1:0] receive_ready_flag,
  output logic [CH_N-1:0] transmit_ready_flag,
  output logic [CH_N-1:0] flow_on_hit,
  output logic [CH_N-1:0] flow_off_hit,
  output logic [CH_N-1:0] address_hit,
  // interrupt request, active low
  output logic interrupt_request_out_n
);

  // ==========================================================
  // helpers
  // zero data bits above the character length
  function automatic logic [7:0] len_mask(input logic [7:0] d,
                                          input logic [1:0] len);
    logic [7:0] m;
    m = 8'hff;
    case (len)
      LEN_5: m = 8'h1f;
      LEN_6: m = 8'h3f;
      LEN_7: m = 8'h7f;
      default: m = 8'hff;
    endcase
    return d & m;
  endfunction

  // level code n means position n+1, so 0..255 covers 1..256
  function automatic logic [8:0] level_pos(input logic [7:0] lv);
    return {1'b0, lv} + 9'h001;
  endfunction

  // ==========================================================
  // shared register port decode
  logic [3:0] reg_off;
  logic reg_ch;
  logic reg_in_ch;
  logic gc_wr;
  logic [7:0] global_config_r;
  logic [CH_N-1:0][10:0] ch_rdata;
  logic [CH_N-1:0][7:0] ch_irq_src;
  logic [10:0] rdata_nxt;
  logic irq_nxt;

  assign reg_off = reg_addr[3:0];
  assign reg_ch = reg_addr[CH_SEL_BIT];
  assign reg_in_ch = (reg_addr[5] == 1'b0);
  assign gc_wr = reg_wr && (reg_addr == GLOBAL_ADDR);

  // read mux: unmapped addresses answer zero
  assign rdata_nxt = !reg_rd ? 11'h000 :
                     (reg_addr == GLOBAL_ADDR) ?
                       {3'h0, global_config_r} :
                     reg_in_ch ? ch_rdata[reg_ch] : 11'h000;

  // any enabled source of either channel pulls the request low
  assign irq_nxt = ~(|ch_irq_src[0] | |ch_irq_src[1]);

  // global config and read data register
  always_ff @(posedge clk) begin
    if (rst) begin
      global_config_r <= RST_GLOBAL;
      reg_rdata <= 11'h000;
      interrupt_request_out_n <= 1'b1;
    end else begin
      if (gc_wr) begin
        global_config_r <= reg_wdata;
      end
      reg_rdata <= rdata_nxt;
      interrupt_request_out_n <= irq_nxt;
    end
  end

  // ==========================================================
  // one copy of everything per channel
  for (genvar c = 0; c < CH_N; c++) begin : g_ch
    logic [10:0] rx_mem [0:FIFO_DEPTH-1];
    logic [7:0] tx_mem [0:FIFO_DEPTH-1];
    logic [PTR_W-1:0] rx_wp_r, rx_rp_r, tx_wp_r, tx_rp_r;
    logic [CNT_W-1:0] rx_cnt_r, tx_cnt_r, tx_free;
    logic [7:0] mask_r, rx_lvl_r, tx_lvl_r;
    logic rx_lvl_own_r, tx_lvl_own_r;
    logic [7:0] flow_on_r, flow_off_r, addr_char_r;
    logic [2:0] err_acc_r, err_acc_nxt, pop_stat_r;
    logic wdog_r, wdog_nxt;
    logic [6:0] wdog_cnt_r;
    logic sel, wr_hit, rd_hit;
    logic rx_push, rx_pop, tx_push, tx_out_load, tx_out_go;
    logic [7:0] rx_thr, tx_thr, rx_byte;
    logic rx_int, tx_int, err_clr, wd_event;
    logic [7:0] interrupt_status, isr_read;
    logic [10:0] rd_sel;
    logic [7:0] out_data_r;
    logic out_valid_r;

    assign sel = reg_in_ch && (reg_ch == 1'(c));
    assign wr_hit = reg_wr && sel;
    assign rd_hit = reg_rd && sel;

    // fifo strobes; a push into a full fifo is dropped
    assign rx_pop = rd_hit && (reg_off == OFF_RXDATA)
                    && (rx_cnt_r != FIFO_EMPTY);
    assign rx_push = rx_load[c] && (rx_cnt_r != FIFO_FULL);
    assign tx_push = wr_hit && (reg_off == OFF_TXDATA)
                     && (tx_cnt_r != FIFO_FULL);
    assign tx_free = FIFO_FULL - tx_cnt_r;

    // output stage holds the head byte; it counts as occupied
    assign tx_out_go = out_valid_r && tx_take[c];
    assign tx_out_load = (!out_valid_r || tx_out_go)
                         && (tx_cnt_r > {8'h00, out_valid_r});

    // own level register wins once written, else mode threshold
    assign rx_thr = rx_lvl_own_r ? rx_lvl_r : mode_rx_level[c];
    assign tx_thr = tx_lvl_own_r ? tx_lvl_r : mode_tx_level[c];
    assign rx_int = rx_cnt_r >= level_pos(rx_thr);
    assign tx_int = tx_free >= level_pos(tx_thr);

    // received byte with unused high bits forced low
    assign rx_byte = len_mask(rx_entry[c].data, char_len[c]);

    // error accumulation; the reset command clears, a new error wins
    assign err_clr = cmd_valid[c] && (cmd_code[c] == CMD_RESET_ERR);
    assign err_acc_nxt = (err_clr ? 3'h0 : err_acc_r)
                         | (rx_push ? {rx_entry[c].brk, rx_entry[c].frm,
                                       rx_entry[c].par} : 3'h0);

    // watchdog fires after 64 idle bit times with data waiting
    assign wd_event = rx_push || rx_pop;
    assign wdog_nxt = (bit_tick[c] && (wdog_cnt_r == WDOG_BIT_TIMES)
                       && (rx_cnt_r != FIFO_EMPTY))
                      || (wdog_r && !rx_pop);

    // interrupt status image
    assign interrupt_status[IS_COS] = ext_stat[c].input_change_detect;
    assign interrupt_status[IS_WDOG] = wdog_r;
    assign interrupt_status[IS_ADDR] = ext_stat[c].addr;
    assign interrupt_status[IS_FLOW] = ext_stat[c].flow;
    assign interrupt_status[IS_CT] = ext_stat[c].ct;
    assign interrupt_status[IS_BRK] = ext_stat[c].brk;
    assign interrupt_status[IS_RX] = rx_int;
    assign interrupt_status[IS_TX] = tx_int;
    assign ch_irq_src[c] = interrupt_status & mask_r;
    assign isr_read = global_config_r[GC_MASKREAD] ?
                      (interrupt_status & mask_r) : interrupt_status;

    // per-channel read mux
    always_comb begin
      rd_sel = 11'h000;
      case (reg_off)
        OFF_MASK: rd_sel = {3'h0, mask_r};
        OFF_STATUS: rd_sel = {3'h0, isr_read};
        OFF_RXDATA: rd_sel = rx_mem[rx_rp_r];
        OFF_RXLEVEL: rd_sel = {3'h0, rx_lvl_r};
        OFF_RXFILL: rd_sel = {3'h0, rx_cnt_r[7:0]};
        OFF_TXLEVEL: rd_sel = {3'h0, tx_lvl_r};
        OFF_TXEMPTY: rd_sel = {3'h0, tx_free[7:0]};
        OFF_FLOW_ON: rd_sel = {3'h0, flow_on_r};
        OFF_FLOW_OFF: rd_sel = {3'h0, flow_off_r};
        OFF_ADDRCHAR: rd_sel = {3'h0, addr_char_r};
        OFF_RXSTAT: rd_sel = {6'h00, pop_stat_r,
                              tx_free != FIFO_EMPTY,
                              rx_cnt_r != FIFO_EMPTY};
        default: rd_sel = 11'h000;
      endcase
    end
    assign ch_rdata[c] = rd_sel;

    // fifo memories carry no reset; the pointers and counts do
    always_ff @(posedge clk) begin
      if (rx_push) begin
        rx_mem[rx_wp_r] <= {rx_entry[c].brk, rx_entry[c].frm,
                            rx_entry[c].par, rx_byte};
      end
      if (tx_push) begin
        tx_mem[tx_wp_r] <= reg_wdata;
      end
    end

    // pointers and counts
    always_ff @(posedge clk) begin
      if (rst) begin
        rx_wp_r <= 8'h00;
        rx_rp_r <= 8'h00;
        tx_wp_r <= 8'h00;
        tx_rp_r <= 8'h00;
        rx_cnt_r <= 9'h000;
        tx_cnt_r <= 9'h000;
      end else begin
        rx_wp_r <= rx_wp_r + {7'h00, rx_push};
        rx_rp_r <= rx_rp_r + {7'h00, rx_pop};
        tx_wp_r <= tx_wp_r + {7'h00, tx_push};
        tx_rp_r <= tx_rp_r + {7'h00, tx_out_load};
        rx_cnt_r <= rx_cnt_r + {8'h00, rx_push} - {8'h00, rx_pop};
        tx_cnt_r <= tx_cnt_r + {8'h00, tx_push} - {8'h00, tx_out_go};
      end
    end

    // transmit head byte, trimmed to the character length
    always_ff @(posedge clk) begin
      if (rst) begin
        out_valid_r <= 1'b0;
        out_data_r <= 8'h00;
      end else if (tx_out_load) begin
        out_valid_r <= 1'b1;
        out_data_r <= len_mask(tx_mem[tx_rp_r], char_len[c]);
      end else if (tx_out_go) begin
        out_valid_r <= 1'b0;
      end
    end

    // software-written registers
    always_ff @(posedge clk) begin
      if (rst) begin
        mask_r <= RST_MASK;
        rx_lvl_r <= RST_LEVEL;
        tx_lvl_r <= RST_LEVEL;
        rx_lvl_own_r <= 1'b0;
        tx_lvl_own_r <= 1'b0;
        flow_on_r <= RST_FLOW_ON;
        flow_off_r <= RST_FLOW_OFF;
        addr_char_r <= RST_ADDRCHAR;
      end else if (wr_hit) begin
        case (reg_off)
          OFF_MASK: mask_r <= reg_wdata;
          OFF_RXLEVEL: begin
            rx_lvl_r <= reg_wdata;
            rx_lvl_own_r <= 1'b1;
          end
          OFF_TXLEVEL: begin
            tx_lvl_r <= reg_wdata;
            tx_lvl_own_r <= 1'b1;
          end
          OFF_FLOW_ON: flow_on_r <= reg_wdata;
          OFF_FLOW_OFF: flow_off_r <= reg_wdata;
          OFF_ADDRCHAR: addr_char_r <= reg_wdata;
          default: mask_r <= mask_r;
        endcase
      end
    end

    // error status, watchdog and popped-entry status
    always_ff @(posedge clk) begin
      if (rst) begin
        err_acc_r <= 3'h0;
        pop_stat_r <= 3'h0;
        wdog_r <= 1'b0;
        wdog_cnt_r <= 7'h00;
      end else begin
        err_acc_r <= err_acc_nxt;
        wdog_r <= wdog_nxt;
        if (wd_event) begin
          wdog_cnt_r <= 7'h00;
        end else if (bit_tick[c] && wdog_cnt_r != WDOG_BIT_TIMES) begin
          wdog_cnt_r <= wdog_cnt_r + 7'h01;
        end
        if (rx_pop) begin
          pop_stat_r <= rx_mem[rx_rp_r][10:8];
        end
      end
    end

    // registered channel outputs and character recognition
    always_ff @(posedge clk) begin
      if (rst) begin
        rx_status[c] <= 3'h0;
        receive_ready_flag[c] <= 1'b0;
        transmit_ready_flag[c] <= 1'b0;
        flow_on_hit[c] <= 1'b0;
        flow_off_hit[c] <= 1'b0;
        address_hit[c] <= 1'b0;
      end else begin
        // block mode shows the running error sum instead
        rx_status[c] <= block_err_mode[c] ? err_acc_nxt
                        : (rx_pop ? rx_mem[rx_rp_r][10:8]
                                  : pop_stat_r);
        receive_ready_flag[c] <= rx_cnt_r != FIFO_EMPTY;
        transmit_ready_flag[c] <= tx_cnt_r != FIFO_FULL;
        flow_on_hit[c] <= rx_push && (rx_byte == flow_on_r);
        flow_off_hit[c] <= rx_push && (rx_byte == flow_off_r);
        address_hit[c] <= rx_push && (rx_byte == addr_char_r);
      end
    end

    assign tx_data[c] = out_data_r;
    assign tx_valid[c] = out_valid_r;
  end

endmodule // ufm_top

// *** tb/ufm_assertions.sv ***
// port-level checks for the fifo/mask/char block.
// assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module ufm_assertions
  import ufm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  // channel sides
  input wire logic [CH_N-1:0] rx_load,
  input wire ufm_ext_stat_t [CH_N-1:0] ext_stat,
  input wire logic [CH_N-1:0] tx_take,
  input wire logic [CH_N-1:0][7:0] tx_data,
  input wire logic [CH_N-1:0] tx_valid,
  input wire logic [CH_N-1:0] receive_ready_flag,
  input wire logic [CH_N-1:0] flow_on_hit,
  input wire logic [CH_N-1:0] flow_off_hit,
  input wire logic [CH_N-1:0] address_hit,
  input wire logic interrupt_request_out_n
);
  // ==========================================================
  logic [7:0] mask_a;
  logic [7:0] mask_b;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // shadow of the mask registers, since they are not visible at ports
  always_ff @(posedge clk) begin
    if (rst) begin
      mask_a <= 8'h00;
      mask_b <= 8'h00;
    end else if (reg_wr && reg_addr == 6'h00) begin
      mask_a <= reg_wdata;
    end else if (reg_wr && reg_addr == 6'h10) begin
      mask_b <= reg_wdata;
    end
  end
  sequence rx_quiet_s;
    rx_load[0] && !reg_rd ##1 !reg_rd;
  endsequence
  sequence wr_tx_s;
    reg_wr && reg_addr == 6'h03;
  endsequence
  mask_off_quiet_a: assert property ((mask_a == 8'h00 && mask_b == 8'h00)
    [*3] |-> interrupt_request_out_n) else $error("irq without mask");
  cos_gate_a: assert property (ext_stat[0].input_change_detect && mask_a[7] |-> ##[0:2]
    !interrupt_request_out_n) else $error("cos irq missing");
  ct_gate_a: assert property (ext_stat[0].ct && mask_a[3] |-> ##[0:2]
    !interrupt_request_out_n) else $error("timer irq missing");
  brk_gate_a: assert property (ext_stat[0].brk && mask_a[2] |-> ##[0:2]
    !interrupt_request_out_n) else $error("break irq missing");
  flow_on_match_a: assert property (flow_on_hit[0] |-> $past(rx_load[0]))
    else $error("flow-on hit without load");
  flow_off_match_a: assert property (flow_off_hit[0] |-> $past(rx_load[0]))
    else $error("flow-off hit without load");
  addr_match_a: assert property (address_hit[0] |-> $past(rx_load[0]))
    else $error("address hit without load");
  rx_ready_a: assert property (rx_quiet_s |-> ##1 receive_ready_flag[0])
    else $error("ready flag missing after load");
  tx_push_a: assert property (wr_tx_s |-> ##[1:3] tx_valid[0])
    else $error("pushed byte never offered");
  tx_hold_a: assert property (tx_valid[0] && !tx_take[0] |=> tx_valid[0]
    && $stable(tx_data[0])) else $error("head byte dropped");
endmodule // ufm_assertions

// *** tb/ufm_line_model.sv ***
// model of one channel's receiver and transmitter state machines.
// assumes the bench requests loads one cycle ahead and may stall.
`timescale 1ns/1ps
module ufm_line_model
  import ufm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bench requests
  input wire logic send,
  input wire ufm_rx_entry_t send_entry,
  input wire logic stall,
  // block side
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic rx_load,
  output ufm_rx_entry_t rx_entry,
  output logic bit_tick,
  output logic tx_take,
  // what the transmitter consumed
  output logic [7:0] got_data,
  output logic [7:0] got_cnt
);
  // ==========================================================
  logic [1:0] div_r;
  // a bit time of four clocks keeps the watchdog wait short
  always_ff @(posedge clk) begin
    div_r <= rst ? 2'h0 : div_r + 2'h1;
    bit_tick <= !rst && div_r == 2'h3;
  end
  // idle entry lines toggle so a stale value is never mistaken for data
  always_ff @(posedge clk) begin
    rx_load <= send && !rst;
    rx_entry <= rst ? '0 : (send ? send_entry : ~rx_entry);
  end
  // one take per offered byte; held until the sampling edge
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_take <= 1'b0;
      got_cnt <= 8'h00;
      got_data <= 8'h00;
    end else begin
      tx_take <= tx_valid && !stall && !tx_take;
      if (tx_take && tx_valid) begin
        got_cnt <= got_cnt + 8'h01;
        got_data <= tx_data;
      end
    end
  end
endmodule // ufm_line_model

// *** tb/ufm_top_bench.sv ***
// self-checking bench: register reads and writes plus line traffic.
// assumes 25 MHz clock and reset held for 20 cycles.
`timescale 1ns/1ps
module ufm_top_bench
  import ufm_pkg::*;
;
  // ==========================================================
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] reg_addr = 6'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [10:0] reg_rdata;
  logic [1:0] rx_load;
  ufm_rx_entry_t [1:0] rx_entry;
  logic [1:0] bit_tick;
  logic [1:0][1:0] char_len = {2'h3, 2'h3};
  logic [1:0] block_err_mode = 2'h0;
  logic [1:0] cmd_valid = 2'h0;
  logic [1:0][7:0] cmd_code = '0;
  logic [1:0][7:0] mode_rx_level = '0;
  logic [1:0][7:0] mode_tx_level = '0;
  ufm_ext_stat_t [1:0] ext_stat = '0;
  logic [1:0] tx_take;
  logic [1:0][7:0] tx_data;
  logic [1:0] tx_valid;
  logic [1:0][2:0] rx_status;
  logic [1:0] receive_ready_flag;
  logic [1:0] transmit_ready_flag;
  logic [1:0] flow_on_hit;
  logic [1:0] flow_off_hit;
  logic [1:0] address_hit;
  logic interrupt_request_out_n;
  logic [1:0] send = 2'h0;
  ufm_rx_entry_t se = '0;
  logic stall = 1'b0;
  logic [7:0] got_data;
  logic [7:0] got_cnt;
  int err_total = 0;
  int comparisons = 0;
  always #20 clk = ~clk;
  ufm_top i_dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .rx_load, .rx_entry, .bit_tick, .char_len,
    .block_err_mode, .cmd_valid, .cmd_code, .mode_rx_level,
    .mode_tx_level, .ext_stat, .tx_take, .tx_data, .tx_valid, .rx_status,
    .receive_ready_flag, .transmit_ready_flag, .flow_on_hit,
    .flow_off_hit, .address_hit, .interrupt_request_out_n);
  ufm_line_model i_lm0 (.clk, .rst, .send(send[0]), .send_entry(se),
    .stall, .tx_data(tx_data[0]), .tx_valid(tx_valid[0]),
    .rx_load(rx_load[0]), .rx_entry(rx_entry[0]),
    .bit_tick(bit_tick[0]), .tx_take(tx_take[0]), .got_data, .got_cnt);
  ufm_line_model i_lm1 (.clk, .rst, .send(send[1]), .send_entry(se),
    .stall, .tx_data(tx_data[1]), .tx_valid(tx_valid[1]),
    .rx_load(rx_load[1]), .rx_entry(rx_entry[1]),
    .bit_tick(bit_tick[1]), .tx_take(tx_take[1]), .got_data(),
    .got_cnt());
  // ==========================================================
  task automatic chk(string nm, logic [10:0] e, logic [10:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wr(logic [5:0] a, logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(logic [5:0] a, logic [10:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk($sformatf("reg_%h", a), e, reg_rdata);
  endtask
  task automatic ld(int c, ufm_rx_entry_t e);
    @(posedge clk);
    send[c] <= 1'b1;
    se <= e;
    @(posedge clk);
    send[c] <= 1'b0;
  endtask
  task automatic cmd(logic [7:0] code);
    @(posedge clk);
    cmd_valid[0] <= 1'b1;
    cmd_code[0] <= code;
    @(posedge clk);
    cmd_valid[0] <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // bounded wait for the request line; running out is a mismatch
  task automatic wait_irq(logic lvl, int n);
    int k;
    k = 0;
    #1;
    while (interrupt_request_out_n !== lvl && k < n) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk("irq_n", {10'h0, lvl}, {10'h0, interrupt_request_out_n});
    if (k >= n && n > 1) tally_and_finish;
  endtask
  // ==========================================================
  logic [3:0] offs [8] = '{4'h0, 4'h4, 4'h6, 4'h8, 4'h9, 4'ha, 4'h5, 4'h7};
  logic [7:0] rstv [8] = '{8'h0, 8'h0, 8'h0, 8'h11, 8'h13, 8'h0, 8'h0, 8'h0};
  int bits [5] = '{7, 5, 4, 3, 2};
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int c = 0; c < 2; c++) begin
      for (int i = 0; i < 8; i++) begin
        rd({1'b0, c[0], offs[i]}, {3'h0, rstv[i]});
      end
    end
    rd(6'h0c, 11'h000);
    wr(6'h18, 8'h5a);
    rd(6'h18, 11'h05a);
    rd(6'h08, 11'h011);
    ld(1, 11'h013);
    @(posedge clk);
    #1 chk("flow_off_hit", 11'h001, {10'h0, flow_off_hit[1]});
    chk("flow_on_hit", 11'h000, {10'h0, flow_on_hit[1]});
    rd(6'h15, 11'h001);
    rd(6'h05, 11'h000);
    ld(1, 11'h05a);
    @(posedge clk);
    #1 chk("flow_on_hit", 11'h001, {10'h0, flow_on_hit[1]});
    chk("address_hit", 11'h000, {10'h0, address_hit[1]});
    ld(1, 11'h000);
    @(posedge clk);
    #1 chk("address_hit", 11'h001, {10'h0, address_hit[1]});
    $display("test registers done");
    ext_stat[0] <= '1;
    repeat (4) @(posedge clk);
    wait_irq(1'b1, 1);
    rd(6'h01, 11'h0bd);
    foreach (bits[i]) begin
      wr(6'h00, 8'h01 << bits[i]);
      wait_irq(1'b0, 6);
      wr(6'h00, 8'h00);
      wait_irq(1'b1, 6);
    end
    wr(6'h20, 8'h01);
    wr(6'h00, 8'h04);
    rd(6'h01, 11'h004);
    wr(6'h00, 8'h00);
    wr(6'h20, 8'h00);
    ext_stat[0] <= '0;
    $display("test mask done");
    wr(6'h04, 8'h02);
    wr(6'h00, 8'h02);
    ld(0, 11'h2a5);
    ld(0, 11'h43c);
    rd(6'h05, 11'h002);
    wait_irq(1'b1, 1);
    ld(0, 11'h1ff);
    wait_irq(1'b0, 6);
    rd(6'h02, 11'h2a5);
    rd(6'h0b, 11'h00b);
    rd(6'h02, 11'h43c);
    rd(6'h0b, 11'h013);
    rd(6'h02, 11'h1ff);
    rd(6'h0b, 11'h006);
    char_len[0] <= LEN_5;
    ld(0, 11'h0ff);
    rd(6'h02, 11'h01f);
    char_len[0] <= 2'h3;
    wr(6'h00, 8'h00);
    for (int i = 0; i < 257; i++) ld(0, {3'h0, i[7:0]});
    rd(6'h05, 11'h000);
    rd(6'h0b, 11'h003);
    for (int i = 0; i < 256; i++) rd(6'h02, {3'h0, i[7:0]});
    rd(6'h0b, 11'h002);
    $display("test receive done");
    wr(6'h00, 8'h40);
    ld(0, 11'h055);
    repeat (200) @(posedge clk);
    wait_irq(1'b1, 1);
    wait_irq(1'b0, 200);
    rd(6'h02, 11'h055);
    wait_irq(1'b1, 4);
    wr(6'h00, 8'h00);
    block_err_mode[0] <= 1'b1;
    cmd(CMD_RESET_ERR);
    ld(0, 11'h155);
    ld(0, 11'h055);
    repeat (2) @(posedge clk);
    #1 chk("rx_status", 11'h001, {8'h0, rx_status[0]});
    cmd(CMD_RESET_ERR);
    #1 chk("rx_status", 11'h000, {8'h0, rx_status[0]});
    block_err_mode[0] <= 1'b0;
    $display("test watchdog and block errors done");
    stall <= 1'b1;
    char_len[0] <= LEN_6;
    wr(6'h03, 8'hff);
    wr(6'h03, 8'h81);
    rd(6'h07, 11'h0fe);
    wr(6'h06, 8'hfe);
    wr(6'h00, 8'h01);
    repeat (2) @(posedge clk);
    wait_irq(1'b1, 1);
    wr(6'h06, 8'hfd);
    wait_irq(1'b0, 6);
    wr(6'h00, 8'h00);
    stall <= 1'b0;
    repeat (10) @(posedge clk);
    #1 chk("got_cnt", 11'h002, {3'h0, got_cnt});
    chk("got_data", 11'h001, {3'h0, got_data});
    chk("tx_ready", 11'h001, {10'h0, transmit_ready_flag[0]});
    rd(6'h07, 11'h000);
    $display("test transmit done");
    tally_and_finish;
  end
endmodule // ufm_top_bench
bind ufm_top ufm_assertions i_chk (.clk, .rst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .rx_load, .ext_stat, .tx_take, .tx_data, .tx_valid,
  .receive_ready_flag, .flow_on_hit, .flow_off_hit, .address_hit,
  .interrupt_request_out_n);
